// ### hdl/sct_pkg.sv
// Package of timing constants and types for the SDRAM command timing engine.
package sct_pkg;
  // Command encodings presented on the command port.
  typedef enum logic [3:0] {
    SCT_CMD_NOP,
    SCT_CMD_MRS,
    SCT_CMD_REF,
    SCT_CMD_ACT,
    SCT_CMD_PRE,
    SCT_CMD_WR,
    SCT_CMD_RD,
    SCT_CMD_ZQCS
  } sct_cmd_t;

  // Burst modes of a write.
  typedef enum logic [1:0] {
    SCT_BURST_BL8,
    SCT_BURST_BC4_OTF,
    SCT_BURST_BC4_FIXED
  } sct_burst_t;

  // Power state as seen by the device.
  typedef enum logic [1:0] {
    SCT_PWR_ACTIVE,
    SCT_PWR_DRAIN,
    SCT_PWR_DOWN,
    SCT_PWR_PPD_FROZEN
  } sct_pwr_t;

  localparam int SCT_CLK_PERIOD_PS = 25000;
  localparam int SCT_CNT_W = 8;
  localparam logic [SCT_CNT_W-1:0] SCT_CNT_ZERO = 8'h00;
  localparam logic [SCT_CNT_W-1:0] SCT_CNT_ONE = 8'h01;
  // Spacing between mode register set commands in clock_cycle_unit.
  localparam logic [SCT_CNT_W-1:0] SCT_MODE_SET_SPACING = 8'h04;
  // Write start offsets beyond write_latency.
  localparam logic [SCT_CNT_W-1:0] SCT_WR_START_BL8 = 8'h04;
  localparam logic [SCT_CNT_W-1:0] SCT_WR_START_BC4_FIXED = 8'h02;
  // ODT high windows.
  localparam logic [SCT_CNT_W-1:0] SCT_ODT_SHORT_HIGH_WINDOW = 8'h04;
  localparam logic [SCT_CNT_W-1:0] SCT_ODT_LONG_HIGH_WINDOW = 8'h06;
  // ZQ short calibration length in clock_cycle_unit.
  localparam logic [SCT_CNT_W-1:0] SCT_ZQCS_CYCLES = 8'h40;
  // Busy time of an internal row/refresh operation, in ns, and as cycles rounded up.
  localparam int SCT_ROW_OP_NS = 110;
  localparam int SCT_ROW_OP_CYC_I = (SCT_ROW_OP_NS * 1000 + SCT_CLK_PERIOD_PS - 1)
                                    / SCT_CLK_PERIOD_PS;
  localparam logic [SCT_CNT_W-1:0] SCT_ROW_OP_CYC = SCT_ROW_OP_CYC_I[SCT_CNT_W-1:0];
  // Write recovery minimum in ns, rounded up to cycles.
  localparam int SCT_WR_MIN_NS = 15;
  localparam int SCT_WR_CYC_I = (SCT_WR_MIN_NS * 1000 + SCT_CLK_PERIOD_PS - 1)
                                / SCT_CLK_PERIOD_PS;
  localparam logic [SCT_CNT_W-1:0] SCT_WR_CYC = SCT_WR_CYC_I[SCT_CNT_W-1:0];
  // Asynchronous termination delay, longest 8.5 ns, rounded down but at least one cycle.
  localparam int SCT_AODT_PS = 8500;
  localparam int SCT_AODT_CYC_I = (SCT_AODT_PS / SCT_CLK_PERIOD_PS) < 1 ? 1
                                  : (SCT_AODT_PS / SCT_CLK_PERIOD_PS);
  localparam logic [SCT_CNT_W-1:0] SCT_AODT_CYC = SCT_AODT_CYC_I[SCT_CNT_W-1:0];
  // Refresh bookkeeping: one regular plus eight posted.
  localparam logic [3:0] SCT_REF_MAX_OWED = 4'h9;
  localparam int SCT_REFI_NS = 7800;
  localparam int SCT_REFI_CYC = SCT_REFI_NS * 1000 / SCT_CLK_PERIOD_PS;
  localparam logic [3:0] SCT_WL_DEFAULT = 4'h5;
endpackage

// ### hdl/sct_delay_line.sv
// Delay line that fires a pulse a programmable number of cycles after a start.
`timescale 1ns/100ps
module sct_delay_line (
  // Clock and reset.
  input wire logic i_mclk,
  input wire logic i_rst,
  // Start request and delay.
  input wire logic i_start,
  input wire logic [sct_pkg::SCT_CNT_W-1:0] i_delay,
  // Output.
  output logic o_fire,
  output logic o_busy
);
  typedef struct packed {
    logic [sct_pkg::SCT_CNT_W-1:0] cnt;
    logic busy;
    logic fire;
  } sct_dl_state_t;

  sct_dl_state_t st_r;
  sct_dl_state_t st_nxt;

  // Count actual clock edges; a new start restarts the count.
  always_comb begin
    st_nxt = st_r;
    st_nxt.fire = 1'b0;
    if (i_start) begin
      st_nxt.cnt = i_delay;
      st_nxt.busy = 1'b1;
    end else if (st_r.busy) begin
      if (st_r.cnt <= sct_pkg::SCT_CNT_ONE) begin
        st_nxt.busy = 1'b0;
        st_nxt.fire = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt - sct_pkg::SCT_CNT_ONE;
      end
    end
  end

  // State register.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_fire = st_r.fire;
  assign o_busy = st_r.busy;
endmodule // sct_delay_line

// ### hdl/sct_timing_engine.sv
// Device-side command timing engine: write start, power-down, ODT, ZQ and refresh state.
// Operation
// - Count spacings in real registered clock edges, e.g. four between mode sets.
// - Row-operation and write-recovery nanosecond parameters become cycle counts rounded up; device honours them.
// - Internal write starts five cycles after write latency, three for fixed chop.
// - CKE low may arrive mid-operation; power-down state waits for completion.
// - Frozen-DLL precharge power-down uses asynchronous termination delays.
// - ZQ short calibration finishes its correction within 64 clock cycles.
`timescale 1ns/100ps
module sct_timing_engine (
  // Clock and reset.
  input wire logic i_mclk,
  input wire logic i_rst,
  // Registered command inputs.
  input wire logic [3:0] i_cmd,
  input wire logic [1:0] i_burst,
  input wire logic [3:0] i_write_latency,
  input wire logic i_cke,
  input wire logic i_odt,
  input wire logic i_dll_frozen,
  input wire logic i_mpr_read_end,
  // Status outputs.
  output logic o_write_start,
  output logic o_op_busy,
  output logic o_pwr_down,
  output logic o_ppd_frozen,
  output logic o_term_on,
  output logic o_zq_busy,
  output logic o_mode_set_ready,
  output logic [3:0] o_ref_owed,
  output logic o_timing_error
);
  typedef struct packed {
    sct_pkg::sct_pwr_t pwr;
    logic [sct_pkg::SCT_CNT_W-1:0] op_cnt;
    logic [sct_pkg::SCT_CNT_W-1:0] mrd_cnt;
    logic [sct_pkg::SCT_CNT_W-1:0] zq_cnt;
    logic [sct_pkg::SCT_CNT_W-1:0] odt_cnt;
    logic [sct_pkg::SCT_CNT_W-1:0] aodt_cnt;
    logic odt_prev;
    logic term_on;
    logic [3:0] ref_owed;
    logic [15:0] refi_cnt;
    logic err;
    logic write_start;
  } sct_state_t;

  localparam logic [15:0] REFI_CYC = sct_pkg::SCT_REFI_CYC[15:0];

  sct_state_t st_r;
  sct_state_t st_nxt;
  sct_pkg::sct_cmd_t cmd;
  logic wr_fire;
  logic [sct_pkg::SCT_CNT_W-1:0] wr_delay;
  logic is_wr;

  assign cmd = sct_pkg::sct_cmd_t'(i_cmd);
  assign is_wr = (cmd == sct_pkg::SCT_CMD_WR) && i_cke;

  // Write start offset after write latency chosen by burst mode.
  always_comb begin
    if (sct_pkg::sct_burst_t'(i_burst) == sct_pkg::SCT_BURST_BC4_FIXED) begin
      wr_delay = {4'h0, i_write_latency} + sct_pkg::SCT_WR_START_BC4_FIXED;
    end else begin
      wr_delay = {4'h0, i_write_latency} + sct_pkg::SCT_WR_START_BL8;
    end
  end

  // Counts edges from the write command to the internal write start.
  sct_delay_line u_wr_delay (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_start(is_wr),
    .i_delay(wr_delay),
    .o_fire(wr_fire),
    .o_busy()
  );

  // Next-state logic for all timing trackers.
  always_comb begin
    st_nxt = st_r;
    st_nxt.write_start = wr_fire;
    st_nxt.odt_prev = i_odt;
    // Down-counters advance once per real clock edge, never by elapsed time.
    if (st_r.op_cnt != sct_pkg::SCT_CNT_ZERO) begin
      st_nxt.op_cnt = st_r.op_cnt - sct_pkg::SCT_CNT_ONE;
    end
    if (st_r.mrd_cnt != sct_pkg::SCT_CNT_ZERO) begin
      st_nxt.mrd_cnt = st_r.mrd_cnt - sct_pkg::SCT_CNT_ONE;
    end
    if (st_r.zq_cnt != sct_pkg::SCT_CNT_ZERO) begin
      st_nxt.zq_cnt = st_r.zq_cnt - sct_pkg::SCT_CNT_ONE;
    end
    if (st_r.odt_cnt != sct_pkg::SCT_CNT_ZERO) begin
      st_nxt.odt_cnt = st_r.odt_cnt - sct_pkg::SCT_CNT_ONE;
    end
    if (i_cke) begin
      unique case (cmd)
        sct_pkg::SCT_CMD_MRS: begin
          // A mode set before the spacing expires is flagged as illegal timing.
          if (st_r.mrd_cnt != sct_pkg::SCT_CNT_ZERO) begin
            st_nxt.err = 1'b1;
          end
          // The taking edge is the first of the four, so the next mode set at Tm+4 is legal.
          st_nxt.mrd_cnt = sct_pkg::SCT_MODE_SET_SPACING - sct_pkg::SCT_CNT_ONE;
        end
        sct_pkg::SCT_CMD_ACT, sct_pkg::SCT_CMD_PRE: begin
          st_nxt.op_cnt = sct_pkg::SCT_ROW_OP_CYC;
        end
        sct_pkg::SCT_CMD_REF: begin
          st_nxt.op_cnt = sct_pkg::SCT_ROW_OP_CYC;
        end
        sct_pkg::SCT_CMD_ZQCS: begin
          st_nxt.zq_cnt = sct_pkg::SCT_ZQCS_CYCLES;
        end
        sct_pkg::SCT_CMD_WR: begin
          st_nxt.op_cnt = wr_delay + sct_pkg::SCT_WR_CYC;
        end
        sct_pkg::SCT_CMD_NOP, sct_pkg::SCT_CMD_RD: begin
        end
        default: begin
        end
      endcase
    end
    // Refresh bookkeeping: interval ticks add debt, refreshes repay it.
    if (st_r.refi_cnt == REFI_CYC - 16'h0001) begin
      st_nxt.refi_cnt = 16'h0000;
      if (st_r.ref_owed >= sct_pkg::SCT_REF_MAX_OWED) begin
        st_nxt.err = 1'b1;
      end else begin
        st_nxt.ref_owed = st_r.ref_owed + 4'h1;
      end
    end else begin
      st_nxt.refi_cnt = st_r.refi_cnt + 16'h0001;
    end
    if (i_cke && cmd == sct_pkg::SCT_CMD_REF && st_nxt.ref_owed != 4'h0) begin
      st_nxt.ref_owed = st_nxt.ref_owed - 4'h1;
    end
    // Power state; CKE low during an operation drains it first.
    unique case (st_r.pwr)
      sct_pkg::SCT_PWR_ACTIVE: begin
        if (!i_cke) begin
          st_nxt.pwr = (st_r.op_cnt != sct_pkg::SCT_CNT_ZERO) ? sct_pkg::SCT_PWR_DRAIN
                       : (i_dll_frozen ? sct_pkg::SCT_PWR_PPD_FROZEN
                          : sct_pkg::SCT_PWR_DOWN);
        end
      end
      sct_pkg::SCT_PWR_DRAIN: begin
        if (i_cke) begin
          st_nxt.pwr = sct_pkg::SCT_PWR_ACTIVE;
        end else if (st_r.op_cnt <= sct_pkg::SCT_CNT_ONE) begin
          st_nxt.pwr = i_dll_frozen ? sct_pkg::SCT_PWR_PPD_FROZEN
                       : sct_pkg::SCT_PWR_DOWN;
        end
      end
      sct_pkg::SCT_PWR_DOWN, sct_pkg::SCT_PWR_PPD_FROZEN: begin
        if (i_cke) begin
          st_nxt.pwr = sct_pkg::SCT_PWR_ACTIVE;
        end
      end
    endcase
    // Termination follows ODT: synchronously, or after async delay when frozen.
    if (st_r.pwr == sct_pkg::SCT_PWR_PPD_FROZEN) begin
      if (i_odt != st_r.term_on) begin
        if (st_r.aodt_cnt >= sct_pkg::SCT_AODT_CYC - sct_pkg::SCT_CNT_ONE) begin
          st_nxt.term_on = i_odt;
          st_nxt.aodt_cnt = sct_pkg::SCT_CNT_ZERO;
        end else begin
          st_nxt.aodt_cnt = st_r.aodt_cnt + sct_pkg::SCT_CNT_ONE;
        end
      end else begin
        st_nxt.aodt_cnt = sct_pkg::SCT_CNT_ZERO;
      end
    end else begin
      st_nxt.term_on = i_odt;
      st_nxt.aodt_cnt = sct_pkg::SCT_CNT_ZERO;
    end
    // ODT high window start; a BL8 write in the window stretches it to the long one, other writes restart the short one.
    if (i_odt && !st_r.odt_prev) begin
      st_nxt.odt_cnt = (is_wr && sct_pkg::sct_burst_t'(i_burst) == sct_pkg::SCT_BURST_BL8)
                       ? sct_pkg::SCT_ODT_LONG_HIGH_WINDOW - sct_pkg::SCT_CNT_ONE
                       : sct_pkg::SCT_ODT_SHORT_HIGH_WINDOW - sct_pkg::SCT_CNT_ONE;
    end else if (i_odt && is_wr) begin
      st_nxt.odt_cnt = (sct_pkg::sct_burst_t'(i_burst) == sct_pkg::SCT_BURST_BL8)
                       ? sct_pkg::SCT_ODT_LONG_HIGH_WINDOW - sct_pkg::SCT_CNT_ONE
                       : sct_pkg::SCT_ODT_SHORT_HIGH_WINDOW - sct_pkg::SCT_CNT_ONE;
    end
    // ODT dropping inside its window is illegal timing.
    if (!i_odt && st_r.odt_prev && st_r.odt_cnt != sct_pkg::SCT_CNT_ZERO) begin
      st_nxt.err = 1'b1;
    end
    // Readout register recovery restarts the mode set spacing.
    if (i_mpr_read_end) begin
      st_nxt.mrd_cnt = sct_pkg::SCT_MODE_SET_SPACING - sct_pkg::SCT_CNT_ONE;
    end
  end

  // State register.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from state flops.
  assign o_write_start = st_r.write_start;
  assign o_op_busy = (st_r.op_cnt != sct_pkg::SCT_CNT_ZERO);
  assign o_pwr_down = (st_r.pwr == sct_pkg::SCT_PWR_DOWN)
                      || (st_r.pwr == sct_pkg::SCT_PWR_PPD_FROZEN);
  assign o_ppd_frozen = (st_r.pwr == sct_pkg::SCT_PWR_PPD_FROZEN);
  assign o_term_on = st_r.term_on;
  assign o_zq_busy = (st_r.zq_cnt != sct_pkg::SCT_CNT_ZERO);
  assign o_mode_set_ready = (st_r.mrd_cnt == sct_pkg::SCT_CNT_ZERO);
  assign o_ref_owed = st_r.ref_owed;
  assign o_timing_error = st_r.err;
endmodule // sct_timing_engine

// ### sim/sct_ctrl_model.sv
// Controller-side model that keeps mode-set and termination spacing.
`timescale 1ns/100ps
module sct_ctrl_model (
  // Clock and reset.
  input wire logic i_mclk,
  input wire logic i_rst,
  // Requests from the bench.
  input wire logic [3:0] i_req_cmd,
  input wire logic [1:0] i_req_burst,
  input wire logic i_req_odt,
  input wire logic i_unsafe,
  // Command bus to the device.
  output logic [3:0] o_cmd,
  output logic [1:0] o_burst,
  output logic o_odt
);
  logic [2:0] gap_r;
  logic [2:0] hold_r;
  logic mrs_go;
  // A too-early mode set is dropped, so only i_unsafe can break the spacing.
  assign mrs_go = (i_req_cmd == 4'h1) && (gap_r == 3'h0 || i_unsafe);
  // Counts run in real clock edges; i_unsafe lets a scenario cut them short.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_cmd <= 4'h0;
      o_burst <= 2'h0;
      o_odt <= 1'b0;
      gap_r <= 3'h0;
      hold_r <= 3'h0;
    end else begin
      o_burst <= i_req_burst;
      o_cmd <= (i_req_cmd == 4'h1 && !mrs_go) ? 4'h0 : i_req_cmd;
      gap_r <= mrs_go ? 3'h3 : (gap_r != 3'h0 ? gap_r - 3'h1 : 3'h0);
      if (i_req_odt && !o_odt) begin
        o_odt <= 1'b1;
        hold_r <= (i_req_cmd == 4'h5 && i_req_burst == 2'h0) ? 3'h5 : 3'h3;
      end else if (hold_r != 3'h0 && !i_unsafe) begin
        hold_r <= hold_r - 3'h1;
      end else begin
        o_odt <= i_req_odt;
      end
    end
  end
endmodule // sct_ctrl_model

// ### sim/sct_timing_properties.sv
// Checker of the timing engine's port behaviour.
`timescale 1ns/100ps
module sct_timing_checker (
  // Clock and reset.
  input wire logic i_mclk,
  input wire logic i_rst,
  // Inputs watched.
  input wire logic [3:0] i_cmd,
  input wire logic [1:0] i_burst,
  input wire logic [3:0] i_write_latency,
  input wire logic i_cke,
  // Outputs watched.
  input wire logic o_write_start,
  input wire logic o_op_busy,
  input wire logic o_pwr_down,
  input wire logic o_zq_busy,
  input wire logic o_mode_set_ready,
  input wire logic [3:0] o_ref_owed,
  input wire logic o_timing_error
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  logic [7:0] since_r;
  logic [7:0] off_r;
  logic [7:0] zq_r;
  logic wr_take;
  assign wr_take = i_cke && i_cmd == 4'h5;
  // Distance from the last write; a later write restarts it, as in the engine.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      since_r <= 8'hFF;
      off_r <= 8'h00;
      zq_r <= 8'h00;
    end else begin
      since_r <= wr_take ? 8'h00 : (since_r == 8'hFF ? 8'hFF : since_r + 8'h01);
      if (wr_take) begin
        off_r <= {4'h0, i_write_latency} + (i_burst == 2'h2 ? 8'h03 : 8'h05);
      end
      zq_r <= o_zq_busy ? zq_r + 8'h01 : 8'h00;
    end
  end
  sequence s_mrs_take;
    i_cke && i_cmd == 4'h1;
  endsequence
  sequence s_ready_low;
    !o_mode_set_ready [*3];
  endsequence
  a_wr_start_offset: assert property (o_write_start |-> since_r == off_r)
    else $error("write start at wrong offset");
  a_wr_start_pulse: assert property (o_write_start |=> !o_write_start)
    else $error("write start longer than one cycle");
  a_mrs_ready_low: assert property (s_mrs_take |=> s_ready_low)
    else $error("mode set ready too early");
  a_mrs_early_err: assert property (i_cke && i_cmd == 4'h1 && !o_mode_set_ready |-> ##[1:2] o_timing_error)
    else $error("early mode set not flagged");
  a_zq_start: assert property (i_cke && i_cmd == 4'h7 && !o_zq_busy |-> ##[1:2] o_zq_busy)
    else $error("calibration did not start");
  a_zq_length: assert property ($fell(o_zq_busy) |-> zq_r == 8'h40)
    else $error("calibration length wrong");
  a_err_sticky: assert property (o_timing_error |=> o_timing_error)
    else $error("timing error cleared without reset");
  a_pd_after_ops: assert property (o_pwr_down |-> !o_op_busy)
    else $error("power-down while an operation runs");
  a_owed_step: assert property (o_ref_owed != $past(o_ref_owed) |->
    (o_ref_owed == $past(o_ref_owed) + 4'h1 || o_ref_owed == $past(o_ref_owed) - 4'h1))
    else $error("refresh debt jumped");
endmodule // sct_timing_checker
bind sct_timing_engine sct_timing_checker u_chk (.i_mclk, .i_rst, .i_cmd, .i_burst,
  .i_write_latency, .i_cke, .o_write_start, .o_op_busy, .o_pwr_down, .o_zq_busy,
  .o_mode_set_ready, .o_ref_owed, .o_timing_error);

// ### sim/tb.sv
// Self-checking bench for the SDRAM command timing engine.
`timescale 1ns/100ps
module tb;
  localparam logic [7:0] WL = 8'h05;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic [3:0] rq_cmd = 4'h0;
  logic [1:0] rq_burst = 2'h0;
  logic rq_odt = 1'b0, unsafe = 1'b0, cke = 1'b1, frozen = 1'b0, mpr_end = 1'b0;
  logic [3:0] cmd, owed;
  logic [1:0] burst;
  logic odt, wr_go, busy, pd, zq, ready, err, ppd;
  int n_fail = 0;
  int cmp_count = 0;
  int cyc = 0;
  // The 40 MHz clock.
  initial begin
    forever #12.5 i_mclk = ~i_mclk;
  end
  sct_ctrl_model u_ctrl (.i_mclk(i_mclk), .i_rst(i_rst), .i_req_cmd(rq_cmd),
    .i_req_burst(rq_burst), .i_req_odt(rq_odt), .i_unsafe(unsafe), .o_cmd(cmd),
    .o_burst(burst), .o_odt(odt));
  sct_timing_engine DUT (.i_mclk(i_mclk), .i_rst(i_rst), .i_cmd(cmd), .i_burst(burst),
    .i_write_latency(WL[3:0]), .i_cke(cke), .i_odt(odt), .i_dll_frozen(frozen),
    .i_mpr_read_end(mpr_end), .o_write_start(wr_go), .o_op_busy(busy), .o_pwr_down(pd),
    .o_ppd_frozen(ppd), .o_term_on(), .o_zq_busy(zq), .o_mode_set_ready(ready),
    .o_ref_owed(owed), .o_timing_error(err));
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // A hang counts as a mismatch and still ends in the verdict.
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      print_verdict();
    end
  end
  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic do_reset();
    @(posedge i_mclk);
    i_rst <= 1'b1;
    repeat (8) @(posedge i_mclk);
    i_rst <= 1'b0;
    #1;
    chk_val({ready, err, owed}, 8'h20);
  endtask
  // The model forwards a request one edge later; the engine takes it on the next edge.
  task automatic send(input logic [3:0] c, input logic [1:0] b);
    @(posedge i_mclk);
    rq_cmd <= c;
    rq_burst <= b;
    @(posedge i_mclk);
    rq_cmd <= 4'h0;
  endtask
  // Counts busy-high cycles over a span under 30, zq-high cycles over a longer one; the count itself is the result.
  task automatic count_high(input int span, output logic [7:0] n);
    n = 8'h00;
    // Sample first, so the cycle right after the launching edge is counted too.
    repeat (span) begin
      #1;
      if (busy === 1'b1 && span < 30) n++;
      if (zq === 1'b1 && span >= 30) n++;
      @(posedge i_mclk);
    end
  endtask
  task automatic t_write(input logic [1:0] b, input logic [7:0] off);
    logic [7:0] at;
    at = 8'hFF;
    send(4'h5, b);
    @(posedge i_mclk);
    for (int k = 1; k < 30; k++) begin
      @(posedge i_mclk);
      #1;
      if (wr_go === 1'b1 && at == 8'hFF) at = 8'(k);
    end
    chk_val(at, off);
    // The write-to-powerdown gap, latency plus start offset plus rounded-up recovery, has long run out.
    chk_val(busy, 8'h00);
    $display("test write done");
  endtask
  task automatic t_mrs();
    send(4'h1, 2'h0);
    send(4'h1, 2'h0);
    repeat (6) @(posedge i_mclk);
    #1;
    chk_val({ready, err}, 8'h02);
    @(posedge i_mclk);
    unsafe <= 1'b1;
    send(4'h1, 2'h0);
    send(4'h1, 2'h0);
    repeat (4) @(posedge i_mclk);
    unsafe <= 1'b0;
    #1;
    chk_val(err, 8'h01);
    do_reset();
    $display("test mode set done");
  endtask
  task automatic t_zq_pd();
    logic [7:0] n;
    send(4'h7, 2'h0);
    count_high(80, n);
    chk_val(n, 8'h40);
    send(4'h3, 2'h0);
    @(posedge i_mclk);
    cke <= 1'b0;
    frozen <= 1'b1;
    mpr_end <= 1'b1;
    count_high(12, n);
    chk_val(n, 8'((110 * 1000 + 24999) / 25000));
    #1;
    chk_val(pd, 8'h01);
    chk_val(ppd, 8'h01);
    chk_val(ready, 8'h00);
    // No read follows the exit, so the locked-DLL exit delay is never owed.
    cke <= 1'b1;
    frozen <= 1'b0;
    mpr_end <= 1'b0;
    $display("test calibration and power-down done");
  endtask
  task automatic t_odt(input logic wr, input int hold, input logic brk, input logic exp);
    @(posedge i_mclk);
    unsafe <= brk;
    rq_odt <= 1'b1;
    rq_burst <= 2'h0;
    rq_cmd <= wr ? 4'h5 : 4'h0;
    @(posedge i_mclk);
    rq_cmd <= 4'h0;
    repeat (hold - 1) @(posedge i_mclk);
    rq_odt <= 1'b0;
    repeat (20) @(posedge i_mclk);
    unsafe <= 1'b0;
    #1;
    chk_val(err, 8'(exp));
    do_reset();
    $display("test termination window done");
  endtask
  task automatic t_ref();
    repeat (330) @(posedge i_mclk);
    #1;
    chk_val(owed, 8'h01);
    send(4'h2, 2'h0);
    repeat (3) @(posedge i_mclk);
    #1;
    chk_val(owed, 8'h00);
    $display("test refresh done");
  endtask
  // Main sequence.
  initial begin
    do_reset();
    t_write(2'h0, WL + 8'h05);
    t_write(2'h1, WL + 8'h05);
    t_write(2'h2, WL + 8'h03);
    t_mrs();
    t_zq_pd();
    t_odt(1'b0, 2, 1'b0, 1'b0);
    t_odt(1'b0, 2, 1'b1, 1'b1);
    t_odt(1'b1, 5, 1'b1, 1'b1);
    t_odt(1'b1, 6, 1'b1, 1'b0);
    t_ref();
    print_verdict();
  end
endmodule // tb
